/* File: rtl/pifsw_pkg.sv */
// constants and types for peripheral interrupt flags and sleep/wake control
package pifsw_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] PERIPHERAL_FLAGS_0_OFS = 12'h70c;
  localparam logic [11:0] PERIPHERAL_FLAGS_1_OFS = 12'h70d;
  localparam logic [11:0] PERIPHERAL_FLAGS_2_OFS = 12'h70e;
  localparam logic [11:0] PERIPHERAL_ENABLES_0_OFS = 12'h716;
  localparam logic [11:0] PERIPHERAL_ENABLES_1_OFS = 12'h717;
  localparam logic [11:0] PERIPHERAL_ENABLES_2_OFS = 12'h718;
  localparam logic [11:0] CORE_CTRL_OFS = 12'h700;
  localparam logic [11:0] SLEEP_STATUS_OFS = 12'h701;
  localparam logic [11:0] OSC_FORCE_OFS = 12'h702;
  localparam logic [11:0] CONVERTER_CTRL_OFS = 12'h703;

  // ****************************************
  // register select codes
  // ****************************************
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_FLAG0 = 4'h1;
  localparam logic [3:0] SEL_ENABLE0 = 4'h4;
  localparam logic [3:0] SEL_CTRL = 4'h7;
  localparam logic [3:0] SEL_STATUS = 4'h8;
  localparam logic [3:0] SEL_OSC = 4'h9;
  localparam logic [3:0] SEL_CONV = 4'ha;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TIMER0_FLAG_BIT = 5;
  localparam int CHANGE_NOTIFY_BIT = 4;
  localparam int EXT_INT_FLAG_BIT = 0;
  localparam int CAPCMP1_FLAG_BIT = 7;
  localparam int TIMER2_FLAG_BIT = 6;
  localparam int TIMER1_FLAG_BIT = 5;
  localparam int SERIAL_RX_FLAG_BIT = 4;
  localparam int SERIAL_TX_FLAG_BIT = 3;
  localparam int BUS_COLLISION_FLAG_BIT = 2;
  localparam int SYNC_SERIAL_FLAG_BIT = 1;
  localparam int CONVERTER_FLAG_BIT = 0;
  localparam int CAPCMP2_FLAG_BIT = 7;
  localparam int MEM_OP_DONE_FLAG_BIT = 6;
  localparam int TIMER_GATE_FLAG_BIT = 5;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPH_IRQ_ENABLE_BIT = 6;
  localparam int TIMEOUT_STATUS_BIT = 4;
  localparam int POWER_DOWN_STATUS_BIT = 3;
  localparam int ASLEEP_BIT = 0;
  localparam int HIGH_OSC_FORCE_BIT = 2;
  localparam int MID_OSC_FORCE_BIT = 1;
  localparam int LOW_OSC_FORCE_BIT = 0;
  localparam int CONVERTER_RC_CLOCK_BIT = 1;
  localparam int CONVERTER_ON_BIT = 0;

  // ****************************************
  // masks and reset values
  // ****************************************
  localparam logic [2:0][7:0] FLAG_IMPL_MASK = {8'he0, 8'hff, 8'h31};
  localparam logic [2:0][7:0] FLAG_LEVEL_MASK = {8'h00, 8'h18, 8'h10};
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OSC_FORCE_RESET = 8'h00;
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  localparam logic STATUS_BIT_RESET = 1'b1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    CCP_CAPTURE,
    CCP_COMPARE,
    CCP_PWM,
    CCP_OFF
  } pifsw_ccp_mode_type;

  typedef enum logic {
    PWR_RUN,
    PWR_SLEEP
  } pifsw_pwr_state_type;

endpackage

/* File: rtl/pifsw_flag_if.sv */
// carrier between the sleep controller and its flag/enable bank
`timescale 1ns/100ps
interface pifsw_flag_if;
  logic wrEn;
  logic [3:0] wrSel;
  logic [7:0] wrData;
  logic [2:0][7:0] stickyEvent;
  logic [2:0][7:0] levelValue;
  logic ccpCapture;
  logic ccpMatch;
  logic ccpTrail;
  pifsw_pkg::pifsw_ccp_mode_type ccpMode;
  logic gateActive;
  logic [2:0][7:0] flags;
  logic [2:0][7:0] enables;

  modport bank (
    input wrEn, wrSel, wrData, stickyEvent, levelValue,
    input ccpCapture, ccpMatch, ccpTrail, ccpMode, gateActive,
    output flags, enables
  );
  modport ctrl (
    output wrEn, wrSel, wrData, stickyEvent, levelValue,
    output ccpCapture, ccpMatch, ccpTrail, ccpMode, gateActive,
    input flags, enables
  );
endinterface

/* File: rtl/pifsw_flag_bank.sv */
// peripheral flag and enable register bank
`timescale 1ns/100ps
module pifsw_flag_bank (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // controller side
  pifsw_flag_if.bank fb
);

  typedef struct packed {
    logic [2:0][7:0] flags;
    logic [2:0][7:0] enables;
    logic gatePrev;
  } pifsw_bank_state_type;

  pifsw_bank_state_type bank_reg;
  pifsw_bank_state_type bank_next;

  // ****************************************
  // flag set and clear
  // ****************************************
  always_comb begin
    logic ccpEvent;
    logic gateFall;
    logic [2:0][7:0] hwSet;
    ccpEvent = 1'b0;
    gateFall = 1'b0;
    hwSet = fb.stickyEvent;
    bank_next = bank_reg;
    bank_next.gatePrev = fb.gateActive;
    case (fb.ccpMode)
      pifsw_pkg::CCP_CAPTURE: begin
        ccpEvent = fb.ccpCapture;
      end
      pifsw_pkg::CCP_COMPARE: begin
        ccpEvent = fb.ccpMatch;
      end
      pifsw_pkg::CCP_PWM: begin
        ccpEvent = fb.ccpTrail;
      end
      default: begin
        ccpEvent = 1'b0;
      end
    endcase
    gateFall = bank_reg.gatePrev & ~fb.gateActive;
    hwSet[2][pifsw_pkg::CAPCMP2_FLAG_BIT] = ccpEvent;
    hwSet[2][pifsw_pkg::TIMER_GATE_FLAG_BIT] = gateFall;
    for (int r = 0; r < 3; r++) begin
      if (fb.wrEn && fb.wrSel == 4'(pifsw_pkg::SEL_FLAG0 + 4'(r))) begin
        bank_next.flags[r] = fb.wrData;
      end
      // set wins over a software clear in the same cycle, enables ignored
      bank_next.flags[r] = bank_next.flags[r] | hwSet[r];
      // read-only level bits follow their source only
      bank_next.flags[r] = (bank_next.flags[r] & ~pifsw_pkg::FLAG_LEVEL_MASK[r]) |
                           (fb.levelValue[r] & pifsw_pkg::FLAG_LEVEL_MASK[r]);
      bank_next.flags[r] = bank_next.flags[r] & pifsw_pkg::FLAG_IMPL_MASK[r];
      if (fb.wrEn && fb.wrSel == 4'(pifsw_pkg::SEL_ENABLE0 + 4'(r))) begin
        bank_next.enables[r] = fb.wrData & pifsw_pkg::FLAG_IMPL_MASK[r];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bank_reg.flags <= {3{pifsw_pkg::FLAG_RESET}};
      bank_reg.enables <= {3{pifsw_pkg::ENABLE_RESET}};
      bank_reg.gatePrev <= 1'b0;
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign fb.flags = bank_reg.flags;
  assign fb.enables = bank_reg.enables;

endmodule

/* File: rtl/pifsw_sleep_ctrl.sv */
// interrupt request, sleep entry and wake-up control with register port
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps

module pifsw_sleep_ctrl #(
  parameter int NUM_PORTS = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // core handshake
  input wire logic sleepExec,
  output logic irqToCore,
  output logic wakeUp,
  output logic isrAfterWake,
  output logic cpuClkEn,
  output logic sysClkEn,
  // watchdog
  input wire logic wdtTimeout,
  output logic wdtClear,
  // reset sources
  input wire logic masterResetPin,
  input wire logic brownoutReset,
  input wire logic powerOnReset,
  output logic deviceResetReq,
  // oscillators
  input wire logic lowOscReq,
  input wire logic midOscReq,
  input wire logic highOscReq,
  output logic lowOscEn,
  output logic midOscEn,
  output logic highOscEn,
  // converter
  input wire logic converterEvent,
  output logic converterAbort,
  output logic converterPowerEn,
  // io ports
  input wire logic [NUM_PORTS-1:0] portPeriphActive,
  output logic [NUM_PORTS-1:0] portHold,
  // peripheral events
  input wire logic timer0Overflow,
  input wire logic changeNotifyPending,
  input wire logic extIntEvent,
  input wire logic capcmp1Event,
  input wire logic timer2Event,
  input wire logic timer1Event,
  input wire logic rxBufNotEmpty,
  input wire logic txBufEmpty,
  input wire logic busCollision,
  input wire logic syncSerialEvent,
  input wire logic capcmp2Capture,
  input wire logic capcmp2Match,
  input wire logic capcmp2PwmTrail,
  input wire logic [1:0] capcmp2Mode,
  input wire logic memOpDone,
  input wire logic timerGateActive
);

  typedef struct packed {
    pifsw_pkg::pifsw_pwr_state_type pwrState;
    logic globalIrqEnable;
    logic periphIrqEnable;
    logic powerDownStatus;
    logic timeoutStatus;
    logic [2:0] oscForce;
    logic converterRcClock;
    logic converterOnBit;
    logic [7:0] rdData;
    logic wakeUp;
    logic isrAfterWake;
    logic wdtClear;
    logic converterAbort;
    logic deviceResetReq;
  } pifsw_ctrl_state_type;

  pifsw_ctrl_state_type ctrl_reg;
  pifsw_ctrl_state_type ctrl_next;

  pifsw_flag_if fb ();

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic [3:0] decodeSel(input logic [11:0] addr);
    logic [3:0] sel;
    sel = pifsw_pkg::SEL_NONE;
    if (addr == pifsw_pkg::PERIPHERAL_FLAGS_0_OFS) begin
      sel = pifsw_pkg::SEL_FLAG0;
    end else if (addr == pifsw_pkg::PERIPHERAL_FLAGS_1_OFS) begin
      sel = 4'(pifsw_pkg::SEL_FLAG0 + 4'h1);
    end else if (addr == pifsw_pkg::PERIPHERAL_FLAGS_2_OFS) begin
      sel = 4'(pifsw_pkg::SEL_FLAG0 + 4'h2);
    end else if (addr == pifsw_pkg::PERIPHERAL_ENABLES_0_OFS) begin
      sel = pifsw_pkg::SEL_ENABLE0;
    end else if (addr == pifsw_pkg::PERIPHERAL_ENABLES_1_OFS) begin
      sel = 4'(pifsw_pkg::SEL_ENABLE0 + 4'h1);
    end else if (addr == pifsw_pkg::PERIPHERAL_ENABLES_2_OFS) begin
      sel = 4'(pifsw_pkg::SEL_ENABLE0 + 4'h2);
    end else if (addr == pifsw_pkg::CORE_CTRL_OFS) begin
      sel = pifsw_pkg::SEL_CTRL;
    end else if (addr == pifsw_pkg::SLEEP_STATUS_OFS) begin
      sel = pifsw_pkg::SEL_STATUS;
    end else if (addr == pifsw_pkg::OSC_FORCE_OFS) begin
      sel = pifsw_pkg::SEL_OSC;
    end else if (addr == pifsw_pkg::CONVERTER_CTRL_OFS) begin
      sel = pifsw_pkg::SEL_CONV;
    end
    return sel;
  endfunction

  // ****************************************
  // flag bank hookup
  // ****************************************
  logic [3:0] wrSel;
  logic [3:0] rdSel;
  assign wrSel = decodeSel(regAddr);
  assign rdSel = wrSel;

  assign fb.wrEn = regWr;
  assign fb.wrSel = wrSel;
  assign fb.wrData = regWrData;
  assign fb.ccpCapture = capcmp2Capture;
  assign fb.ccpMatch = capcmp2Match;
  assign fb.ccpTrail = capcmp2PwmTrail;
  assign fb.ccpMode = pifsw_pkg::pifsw_ccp_mode_type'(capcmp2Mode);
  assign fb.gateActive = timerGateActive;
  assign fb.stickyEvent[0] = {2'b00, timer0Overflow, 4'h0, extIntEvent};
  assign fb.stickyEvent[1] = {capcmp1Event, timer2Event, timer1Event, 2'b00,
                              busCollision, syncSerialEvent, converterEvent};
  assign fb.stickyEvent[2] = {1'b0, memOpDone, 6'h00};
  assign fb.levelValue[0] = {3'b000, changeNotifyPending, 4'h0};
  assign fb.levelValue[1] = {3'b000, rxBufNotEmpty, txBufEmpty, 3'b000};
  assign fb.levelValue[2] = 8'h00;

  pifsw_flag_bank u_flag_bank (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .fb(fb.bank)
  );

  // ****************************************
  // request forming
  // ****************************************
  logic [2:0] regPending;
  logic wakeRequest;
  logic pendingInBlock;

  generate
    for (genvar r = 0; r < 3; r++) begin : g_pend
      assign regPending[r] = |(fb.flags[r] & fb.enables[r]);
    end
  endgenerate

  // wake ignores both global and peripheral enable gates
  assign wakeRequest = |regPending;
  assign pendingInBlock = regPending[0] | (ctrl_reg.periphIrqEnable & (regPending[1] | regPending[2]));
  assign irqToCore = ctrl_reg.globalIrqEnable & pendingInBlock & (ctrl_reg.pwrState == pifsw_pkg::PWR_RUN);

  // ****************************************
  // control and sleep sequencing
  // ****************************************
  always_comb begin
    logic [7:0] rdValue;
    rdValue = 8'h00;
    ctrl_next = ctrl_reg;
    ctrl_next.wakeUp = 1'b0;
    ctrl_next.isrAfterWake = 1'b0;
    ctrl_next.wdtClear = 1'b0;
    ctrl_next.converterAbort = 1'b0;
    ctrl_next.deviceResetReq = masterResetPin | brownoutReset | powerOnReset;

    if (regWr) begin
      if (wrSel == pifsw_pkg::SEL_CTRL) begin
        ctrl_next.globalIrqEnable = regWrData[pifsw_pkg::GLOBAL_IRQ_ENABLE_BIT];
        ctrl_next.periphIrqEnable = regWrData[pifsw_pkg::PERIPH_IRQ_ENABLE_BIT];
      end else if (wrSel == pifsw_pkg::SEL_OSC) begin
        ctrl_next.oscForce = {regWrData[pifsw_pkg::HIGH_OSC_FORCE_BIT],
                              regWrData[pifsw_pkg::MID_OSC_FORCE_BIT],
                              regWrData[pifsw_pkg::LOW_OSC_FORCE_BIT]};
      end else if (wrSel == pifsw_pkg::SEL_CONV) begin
        ctrl_next.converterRcClock = regWrData[pifsw_pkg::CONVERTER_RC_CLOCK_BIT];
        ctrl_next.converterOnBit = regWrData[pifsw_pkg::CONVERTER_ON_BIT];
      end
    end

    case (ctrl_reg.pwrState)
      pifsw_pkg::PWR_RUN: begin
        if (sleepExec) begin
          if (wakeRequest && !ctrl_reg.globalIrqEnable) begin
            ctrl_next.pwrState = pifsw_pkg::PWR_RUN;
          end else begin
            ctrl_next.pwrState = pifsw_pkg::PWR_SLEEP;
            ctrl_next.powerDownStatus = 1'b0;
            ctrl_next.timeoutStatus = 1'b1;
            ctrl_next.wdtClear = 1'b1;
            ctrl_next.converterAbort = ctrl_reg.converterOnBit & ~ctrl_reg.converterRcClock;
          end
        end
      end
      pifsw_pkg::PWR_SLEEP: begin
        if (wdtTimeout || wakeRequest) begin
          if (wdtTimeout) begin
            ctrl_next.timeoutStatus = 1'b0;
            ctrl_next.powerDownStatus = 1'b0;
          end
          ctrl_next.pwrState = pifsw_pkg::PWR_RUN;
          ctrl_next.wdtClear = 1'b1;
          ctrl_next.wakeUp = 1'b1;
          ctrl_next.isrAfterWake = ctrl_reg.globalIrqEnable & wakeRequest;
        end
      end
      default: begin
        ctrl_next.pwrState = pifsw_pkg::PWR_RUN;
      end
    endcase

    if (rdSel >= pifsw_pkg::SEL_FLAG0 && rdSel < pifsw_pkg::SEL_ENABLE0) begin
      rdValue = fb.flags[2'(rdSel - pifsw_pkg::SEL_FLAG0)];
    end else if (rdSel >= pifsw_pkg::SEL_ENABLE0 && rdSel < pifsw_pkg::SEL_CTRL) begin
      rdValue = fb.enables[2'(rdSel - pifsw_pkg::SEL_ENABLE0)];
    end else if (rdSel == pifsw_pkg::SEL_CTRL) begin
      rdValue[pifsw_pkg::GLOBAL_IRQ_ENABLE_BIT] = ctrl_reg.globalIrqEnable;
      rdValue[pifsw_pkg::PERIPH_IRQ_ENABLE_BIT] = ctrl_reg.periphIrqEnable;
    end else if (rdSel == pifsw_pkg::SEL_STATUS) begin
      rdValue[pifsw_pkg::TIMEOUT_STATUS_BIT] = ctrl_reg.timeoutStatus;
      rdValue[pifsw_pkg::POWER_DOWN_STATUS_BIT] = ctrl_reg.powerDownStatus;
      rdValue[pifsw_pkg::ASLEEP_BIT] = (ctrl_reg.pwrState == pifsw_pkg::PWR_SLEEP);
    end else if (rdSel == pifsw_pkg::SEL_OSC) begin
      rdValue[pifsw_pkg::HIGH_OSC_FORCE_BIT] = ctrl_reg.oscForce[2];
      rdValue[pifsw_pkg::MID_OSC_FORCE_BIT] = ctrl_reg.oscForce[1];
      rdValue[pifsw_pkg::LOW_OSC_FORCE_BIT] = ctrl_reg.oscForce[0];
    end else if (rdSel == pifsw_pkg::SEL_CONV) begin
      rdValue[pifsw_pkg::CONVERTER_RC_CLOCK_BIT] = ctrl_reg.converterRcClock;
      rdValue[pifsw_pkg::CONVERTER_ON_BIT] = ctrl_reg.converterOnBit;
    end
    ctrl_next.rdData = regRd ? rdValue : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg.pwrState <= pifsw_pkg::PWR_RUN;
      ctrl_reg.globalIrqEnable <= pifsw_pkg::CTRL_RESET[pifsw_pkg::GLOBAL_IRQ_ENABLE_BIT];
      ctrl_reg.periphIrqEnable <= pifsw_pkg::CTRL_RESET[pifsw_pkg::PERIPH_IRQ_ENABLE_BIT];
      ctrl_reg.powerDownStatus <= pifsw_pkg::STATUS_BIT_RESET;
      ctrl_reg.timeoutStatus <= pifsw_pkg::STATUS_BIT_RESET;
      ctrl_reg.oscForce <= pifsw_pkg::OSC_FORCE_RESET[2:0];
      ctrl_reg.converterRcClock <= pifsw_pkg::CONV_CTRL_RESET[pifsw_pkg::CONVERTER_RC_CLOCK_BIT];
      ctrl_reg.converterOnBit <= pifsw_pkg::CONV_CTRL_RESET[pifsw_pkg::CONVERTER_ON_BIT];
      ctrl_reg.rdData <= 8'h00;
      ctrl_reg.wakeUp <= 1'b0;
      ctrl_reg.isrAfterWake <= 1'b0;
      ctrl_reg.wdtClear <= 1'b0;
      ctrl_reg.converterAbort <= 1'b0;
      ctrl_reg.deviceResetReq <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic asleep;
  assign asleep = (ctrl_reg.pwrState == pifsw_pkg::PWR_SLEEP);

  assign regRdData = ctrl_reg.rdData;
  assign wakeUp = ctrl_reg.wakeUp;
  assign isrAfterWake = ctrl_reg.isrAfterWake;
  assign wdtClear = ctrl_reg.wdtClear;
  assign deviceResetReq = ctrl_reg.deviceResetReq;
  assign converterAbort = ctrl_reg.converterAbort;
  assign cpuClkEn = ~asleep;
  assign sysClkEn = ~asleep;
  assign lowOscEn = ~asleep | lowOscReq | ctrl_reg.oscForce[0];
  assign midOscEn = ~asleep | midOscReq | ctrl_reg.oscForce[1];
  assign highOscEn = ~asleep | highOscReq | ctrl_reg.oscForce[2];
  // on bit stays set while the converter is powered down
  assign converterPowerEn = ctrl_reg.converterOnBit & (~asleep | ctrl_reg.converterRcClock);
  assign portHold = asleep ? ~portPeriphActive : '0;

endmodule

/* File: testbench/pifsw_sleep_ctrl_checker.sv */
// port assertions for the sleep and interrupt controller
`timescale 1ns/100ps
module pifsw_sleep_ctrl_checker #(
  parameter int NUM_PORTS = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // observed ports
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic irqToCore,
  input wire logic wakeUp,
  input wire logic isrAfterWake,
  input wire logic cpuClkEn,
  input wire logic sysClkEn,
  input wire logic wdtTimeout,
  input wire logic wdtClear,
  input wire logic masterResetPin,
  input wire logic deviceResetReq,
  input wire logic lowOscReq,
  input wire logic lowOscEn,
  input wire logic converterAbort,
  input wire logic [NUM_PORTS-1:0] portPeriphActive,
  input wire logic [NUM_PORTS-1:0] portHold
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // assertions
  // ****************************************
  AST_READ_IDLE_ZERO:
    assert property (!$past(regRd) |-> regRdData == 8'h00) else $error("read data outside read slot");
  AST_ENTRY_CLEARS_WDT:
    assert property ($fell(cpuClkEn) |-> wdtClear) else $error("no watchdog clear on sleep entry");
  AST_WAKE_CLEARS_WDT:
    assert property (wakeUp |-> wdtClear && cpuClkEn && !$past(cpuClkEn)) else $error("bad wake pulse");
  AST_WDT_WAKES:
    assert property (!cpuClkEn && wdtTimeout |=> wakeUp) else $error("watchdog did not wake");
  AST_RESET_SOURCE:
    assert property (masterResetPin |=> deviceResetReq) else $error("reset pin not forwarded");
  AST_CLOCKS_STOP:
    assert property (!cpuClkEn |-> !sysClkEn && !irqToCore) else $error("clocks or request live in sleep");
  AST_OSC_KEPT:
    assert property (lowOscReq |-> lowOscEn) else $error("requested oscillator stopped");
  AST_ISR_ONLY_ON_WAKE:
    assert property (isrAfterWake |-> wakeUp) else $error("service flag without wake");
  AST_WAKE_ONE_CYCLE:
    assert property (wakeUp |=> !wakeUp) else $error("wake pulse too long");
  AST_ABORT_AT_ENTRY:
    assert property (converterAbort |-> $fell(cpuClkEn)) else $error("abort outside sleep entry");
  AST_PORT_HOLD:
    assert property (portHold == ({NUM_PORTS{!cpuClkEn}} & ~portPeriphActive)) else $error("port hold wrong");
  // ****************************************
  // covers
  // ****************************************
  COV_SLEEP: cover property ($fell(cpuClkEn));
  COV_ISR_WAKE: cover property (wakeUp && isrAfterWake);
  COV_ABORT: cover property (converterAbort);
endmodule
bind pifsw_sleep_ctrl pifsw_sleep_ctrl_checker #(.NUM_PORTS(NUM_PORTS)) u_pifsw_sleep_ctrl_checker (
  .sys_clk(sys_clk), .nrst(nrst), .regRd(regRd), .regRdData(regRdData), .irqToCore(irqToCore),
  .wakeUp(wakeUp), .isrAfterWake(isrAfterWake), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn),
  .wdtTimeout(wdtTimeout), .wdtClear(wdtClear), .masterResetPin(masterResetPin),
  .deviceResetReq(deviceResetReq), .lowOscReq(lowOscReq), .lowOscEn(lowOscEn),
  .converterAbort(converterAbort), .portPeriphActive(portPeriphActive), .portHold(portHold)
);

/* File: testbench/pifsw_periph_model.sv */
// peripheral event sources feeding the controller
`timescale 1ns/100ps
module pifsw_periph_model (
  // clock
  input wire logic sys_clk,
  // one request bit per source
  input wire logic [7:0] kick,
  // event lines
  output logic busCollision,
  output logic syncSerialEvent,
  output logic converterEvent,
  output logic memOpDone,
  output logic capcmp2Capture,
  output logic capcmp2Match,
  output logic capcmp2PwmTrail,
  output logic timerGateActive
);
  // one-cycle pulses; gate rests active, drops for one cycle
  always_ff @(posedge sys_clk) begin
    {capcmp2PwmTrail, capcmp2Match, capcmp2Capture, memOpDone} <= kick[6:3];
    {converterEvent, syncSerialEvent, busCollision} <= kick[2:0];
    timerGateActive <= ~kick[7];
  end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the sleep and interrupt controller
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sleepExec = 1'b0;
  logic wdtTimeout = 1'b0;
  logic [2:0] rstSrc = 3'h0;
  logic [2:0] oscReq = 3'h0;
  logic [2:0] portAct = 3'h0;
  logic [5:0] misc = 6'h00;
  logic rxNe = 1'b0;
  logic txEmp = 1'b0;
  logic [1:0] ccMode = 2'h0;
  logic [7:0] kick = 8'h00;
  logic [7:0] regRdData;
  logic irqToCore, wakeUp, isrAfterWake, cpuClkEn, sysClkEn, wdtClear, deviceResetReq;
  logic lowOscEn, midOscEn, highOscEn, converterAbort, converterPowerEn;
  logic coll, syncEv, convEv, memDone, ccCap, ccMatch, ccTrail, gateAct;
  logic [2:0] portHold;
  logic [7:0] expQ[$];
  logic rdSeen = 1'b0;
  logic [7:0] rnd;
  int errors = 0;
  int total_checks = 0;
  int m;
  always #2 sys_clk = ~sys_clk;
  pifsw_sleep_ctrl #(.NUM_PORTS(3)) u_pifsw_sleep_ctrl (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .sleepExec(sleepExec), .irqToCore(irqToCore), .wakeUp(wakeUp),
    .isrAfterWake(isrAfterWake), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn), .wdtTimeout(wdtTimeout),
    .wdtClear(wdtClear), .masterResetPin(rstSrc[0]), .brownoutReset(rstSrc[1]), .powerOnReset(rstSrc[2]),
    .deviceResetReq(deviceResetReq), .lowOscReq(oscReq[0]), .midOscReq(oscReq[1]), .highOscReq(oscReq[2]),
    .lowOscEn(lowOscEn), .midOscEn(midOscEn), .highOscEn(highOscEn), .converterEvent(convEv),
    .converterAbort(converterAbort), .converterPowerEn(converterPowerEn), .portPeriphActive(portAct),
    .portHold(portHold), .timer0Overflow(misc[5]), .changeNotifyPending(misc[0]), .extIntEvent(misc[4]),
    .capcmp1Event(misc[3]), .timer2Event(misc[2]), .timer1Event(misc[1]), .rxBufNotEmpty(rxNe),
    .txBufEmpty(txEmp), .busCollision(coll), .syncSerialEvent(syncEv), .capcmp2Capture(ccCap),
    .capcmp2Match(ccMatch), .capcmp2PwmTrail(ccTrail), .capcmp2Mode(ccMode), .memOpDone(memDone),
    .timerGateActive(gateAct)
  );
  pifsw_periph_model u_pifsw_periph_model (
    .sys_clk(sys_clk), .kick(kick), .busCollision(coll), .syncSerialEvent(syncEv), .converterEvent(convEv),
    .memOpDone(memDone), .capcmp2Capture(ccCap), .capcmp2Match(ccMatch), .capcmp2PwmTrail(ccTrail),
    .timerGateActive(gateAct)
  );
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask
  task automatic fire(input logic [7:0] k);
    @(posedge sys_clk);
    kick <= k;
    @(posedge sys_clk);
    kick <= 8'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic sleepGo(input logic abortExp);
    @(posedge sys_clk);
    sleepExec <= 1'b1;
    @(posedge sys_clk);
    sleepExec <= 1'b0;
    @(negedge sys_clk);
    check({7'h00, converterAbort}, {7'h00, abortExp});
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic waitWake(input logic isr);
    int n;
    n = 0;
    while (wakeUp !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check({6'h00, wakeUp, isrAfterWake}, {6'h00, 1'b1, isr});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // read monitor
  // ****************************************
  always @(negedge sys_clk) begin
    if (rdSeen) begin
      check(regRdData, expQ.pop_front());
    end
    rdSeen = regRd;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("ERROR %0t: timeout", $time);
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h50ce));
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(12'h70e, 8'h00);
    rd(12'h701, 8'h18);
    misc <= 6'h3f;
    rxNe <= 1'b1;
    @(posedge sys_clk);
    misc <= 6'h00;
    fire(8'h8f);
    rd(12'h70c, 8'h21);
    rd(12'h70d, 8'hf7);
    rd(12'h70e, 8'h60);
    rxNe <= 1'b0;
    txEmp <= 1'b1;
    wr(12'h70d, 8'h18);
    rd(12'h70d, 8'h08);
    for (m = 0; m < 3; m++) begin
      ccMode <= 2'(m);
      wr(12'h70e, 8'h00);
      fire(8'h10 << ((m + 1) % 3));
      rd(12'h70e, 8'h00);
      fire(8'h10 << m);
      rd(12'h70e, 8'h80);
    end
    for (m = 0; m < 3; m++) begin
      rnd = 8'($urandom());
      wr(12'h716 + 12'(m), rnd);
      rd(12'h716 + 12'(m), rnd & pifsw_pkg::FLAG_IMPL_MASK[m]);
    end
    wr(12'h715, 8'hff);
    rd(12'h715, 8'h00);
    wr(12'h716, 8'h00);
    wr(12'h718, 8'h00);
    wr(12'h70d, 8'h00);
    wr(12'h717, 8'h04);
    wr(12'h700, 8'h80);
    fire(8'h01);
    @(negedge sys_clk);
    check({7'h00, irqToCore}, 8'h00);
    wr(12'h700, 8'hc0);
    @(negedge sys_clk);
    check({7'h00, irqToCore}, 8'h01);
    wr(12'h700, 8'h00);
    sleepGo(1'b0);
    rd(12'h701, 8'h18);
    wr(12'h700, 8'h80);
    fork
      sleepGo(1'b0);
      waitWake(1'b1);
    join
    rd(12'h701, 8'h10);
    wr(12'h700, 8'h00);
    wr(12'h70d, 8'h00);
    wr(12'h703, 8'h01);
    wr(12'h702, 8'h02);
    portAct <= 3'($urandom());
    oscReq <= 3'($urandom());
    sleepGo(1'b1);
    @(negedge sys_clk);
    check({6'h00, cpuClkEn, converterPowerEn}, 8'h00);
    check({5'h00, highOscEn, midOscEn, lowOscEn}, {5'h00, oscReq | 3'h2});
    rd(12'h703, 8'h01);
    rd(12'h701, 8'h11);
    fork
      fire(8'h01);
      waitWake(1'b0);
    join
    wr(12'h70d, 8'h00);
    wr(12'h703, 8'h03);
    sleepGo(1'b0);
    @(negedge sys_clk);
    check({7'h00, converterPowerEn}, 8'h01);
    fork
      begin
        @(posedge sys_clk);
        wdtTimeout <= 1'b1;
        @(posedge sys_clk);
        wdtTimeout <= 1'b0;
      end
      waitWake(1'b0);
    join
    rd(12'h701, 8'h00);
    for (m = 0; m < 3; m++) begin
      rstSrc <= 3'(1 << m);
      @(posedge sys_clk);
      rstSrc <= 3'h0;
      @(negedge sys_clk);
      check({7'h00, deviceResetReq}, 8'h01);
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    wrap_up();
  end
endmodule
